// ===== logic/sfpi_pkg.sv
// shared constants, states and types of the serial flash pin front end
package sfpi_pkg;

  // ==========================================================
  // widths
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned CNT_W   = 3;
  localparam int unsigned PIN_N   = 5;
  localparam int unsigned SYNC_N  = 3;

  // ==========================================================
  // index of each sampled pin in the synchroniser bank
  localparam int unsigned PIN_CS    = 0;
  localparam int unsigned PIN_SCK   = 1;
  localparam int unsigned PIN_DIN   = 2;
  localparam int unsigned PIN_WP    = 3;
  localparam int unsigned PIN_PAUSE = 4;

  // reset level of each pin: select, protect and pause idle high
  localparam logic [PIN_N-1:0] PIN_IDLE = 5'h19;

  // ==========================================================
  // reset values and step sizes
  localparam logic [CNT_W-1:0]  CNT_RST   = 3'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 3'h1;
  localparam logic [CNT_W-1:0]  CNT_TWO   = 3'h2;
  localparam logic [CNT_W-1:0]  CNT_LAST  = 3'h7;
  localparam logic [BYTE_W-1:0] BYTE_RST  = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_FILL = 8'hFF;

  // ==========================================================
  // frame state
  typedef enum logic [1:0] {
    SFPI_DESEL  = 2'b00,
    SFPI_SEL    = 2'b01,
    SFPI_FINISH = 2'b10
  } sfpi_state_type;

  // ==========================================================
  // state of the pin front end apart from the received byte buffer
  typedef struct packed {
    logic [PIN_N-1:0][SYNC_N-1:0] sync;
    logic [PIN_N-1:0]             filt;
    logic                         sck_prev;
    logic                         cs_prev;
    sfpi_state_type               fsm;
    logic                         hold;
    logic [CNT_W-1:0]             rx_cnt;
    logic [BYTE_W-1:0]            rx_shift;
    logic [BYTE_W-1:0]            push_data;
    logic                         push;
    logic [BYTE_W-1:0]            tx_shift;
    logic [CNT_W-1:0]             tx_cnt;
    logic                         lane1_out;
    logic                         lane1_oe;
    logic                         lane0_out;
    logic                         lane0_oe;
    logic                         tx_load;
    logic                         overrun;
    logic                         frame_start;
    logic                         frame_end;
    logic                         standby;
    logic                         hw_lock;
  } sfpi_core_type;

endpackage : sfpi_pkg

// ===== logic/sfpi_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module sfpi_buf2 #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // filling side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  // draining side
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);

  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic             head_v;
    logic             tail_v;
  } sfpi_buf_type;

  sfpi_buf_type q;
  sfpi_buf_type next_q;
  logic         push;
  logic         pop;

  // ==========================================================
  // head is always the oldest word, tail the one behind it
  always_comb begin
    next_q = q;
    push   = in_valid & ~q.tail_v;
    pop    = q.head_v & out_ready;
    if (pop) begin
      next_q.head   = q.tail;
      next_q.head_v = q.tail_v;
      next_q.tail_v = 1'b0;
    end
    if (push) begin
      if (!next_q.head_v) begin
        next_q.head   = in_data;
        next_q.head_v = 1'b1;
      end else begin
        next_q.tail   = in_data;
        next_q.tail_v = 1'b1;
      end
    end
    if (rst) begin
      next_q = '0;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    q <= next_q;
  end

  assign in_ready  = ~q.tail_v;
  assign out_valid = q.head_v;
  assign out_data  = q.head;

endmodule : sfpi_buf2

`default_nettype wire

// ===== logic/sfpi_top.sv
// serial flash pin front end: select framing, bit shifting, dual read lanes, pause and protect sensing
// Operation
// - select high deselects, standby when idle, output lane one floats
// - while deselected, the input lane is ignored completely
// - frames open on select falling and close on select rising
// - after select rises, standby waits for a self-timed operation to finish
// - input bits are sampled on each rising serial clock edge
// - output bits change on each falling serial clock edge
// - dual read turns the input lane into an output, two bits per edge
// - active-low protect pin enables hardware locking, idles deasserted
// - pause ignores clock and input, floats outputs, keeps selection
// - pause starts only when selected with clock low, self-timed work continues
`timescale 1ns/1ns
`default_nettype none

module sfpi_top (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // serial pins
  input  wire logic                        chip_select_n,
  input  wire logic                        serial_clk,
  input  wire logic                        din_lane0_in,
  output var  logic                        din_lane0_out,
  output var  logic                        din_lane0_oe,
  output var  logic                        dout_lane1_out,
  output var  logic                        dout_lane1_oe,
  input  wire logic                        write_protect_n,
  input  wire logic                        pause_n,
  // command core controls
  input  wire logic                        read_phase,
  input  wire logic                        dual_read,
  input  wire logic                        self_timed_busy,
  // outgoing read bytes
  input  wire logic [sfpi_pkg::BYTE_W-1:0] tx_data,
  output var  logic                        tx_load,
  // incoming bytes
  output var  logic [sfpi_pkg::BYTE_W-1:0] rx_data,
  output var  logic                        rx_valid,
  input  wire logic                        rx_ready,
  output var  logic                        rx_overrun,
  // frame and pin status
  output var  logic                        frame_start,
  output var  logic                        frame_end,
  output var  logic                        standby,
  output var  logic                        hw_lock,
  output var  logic                        paused
);

  import sfpi_pkg::*;

  sfpi_core_type     q;
  sfpi_core_type     next_q;
  logic [PIN_N-1:0]  pins;
  logic              buf_ready;
  logic              cs_fall;
  logic              cs_rise;
  logic              sck_rise;
  logic              sck_fall;
  logic              active;
  logic              rx_fire;
  logic              tx_fire;
  logic [BYTE_W-1:0] word;

  assign pins = {pause_n, write_protect_n, din_lane0_in, serial_clk, chip_select_n};

  // ==========================================================
  // next-state logic
  always_comb begin
    next_q             = q;
    word               = q.tx_shift;
    next_q.push        = 1'b0;
    next_q.tx_load     = 1'b0;
    next_q.frame_start = 1'b0;
    next_q.frame_end   = 1'b0;
    // three-stage sampling; a level counts once stages two and three agree
    for (int i = 0; i < PIN_N; i++) begin
      next_q.sync[i] = {q.sync[i][1:0], pins[i]};
      if (q.sync[i][1] == q.sync[i][2]) begin
        next_q.filt[i] = q.sync[i][1];
      end
    end
    next_q.sck_prev = q.filt[PIN_SCK];
    next_q.cs_prev  = q.filt[PIN_CS];
    cs_fall  = q.cs_prev & ~q.filt[PIN_CS];
    cs_rise  = ~q.cs_prev & q.filt[PIN_CS];
    sck_rise = ~q.sck_prev & q.filt[PIN_SCK];
    sck_fall = q.sck_prev & ~q.filt[PIN_SCK];
    // framing by select edges only
    case (q.fsm)
      SFPI_DESEL: begin
        if (cs_fall) begin
          next_q.fsm         = SFPI_SEL;
          next_q.frame_start = 1'b1;
          next_q.rx_cnt      = CNT_RST;
          next_q.tx_cnt      = CNT_RST;
        end
      end
      SFPI_SEL: begin
        if (cs_rise) begin
          next_q.frame_end = 1'b1;
          next_q.hold      = 1'b0;
          next_q.fsm       = self_timed_busy ? SFPI_FINISH : SFPI_DESEL;
        end
      end
      SFPI_FINISH: begin
        if (cs_fall) begin
          next_q.fsm         = SFPI_SEL;
          next_q.frame_start = 1'b1;
          next_q.rx_cnt      = CNT_RST;
          next_q.tx_cnt      = CNT_RST;
        end else if (!self_timed_busy) begin
          next_q.fsm = SFPI_DESEL;
        end
      end
      default: begin
        next_q.fsm = SFPI_DESEL;
      end
    endcase
    // pause starts only selected with clock low; the busy path above is untouched
    if (q.fsm == SFPI_SEL && !cs_rise) begin
      if (!q.hold && !q.filt[PIN_PAUSE] && !q.filt[PIN_SCK]) begin
        next_q.hold = 1'b1;
      end else if (q.hold && q.filt[PIN_PAUSE]) begin
        next_q.hold = 1'b0;
      end
    end
    // clock edges count only inside an open, unpaused frame
    active  = (q.fsm == SFPI_SEL) && !q.hold && !cs_rise;
    rx_fire = active && sck_rise && !dual_read;
    tx_fire = active && sck_fall && read_phase;
    // shift in on rising edges, msb first
    if (rx_fire) begin
      next_q.rx_shift = {q.rx_shift[BYTE_W-2:0], q.filt[PIN_DIN]};
      next_q.rx_cnt   = q.rx_cnt + CNT_ONE;
      if (q.rx_cnt == CNT_LAST) begin
        next_q.push      = 1'b1;
        next_q.push_data = {q.rx_shift[BYTE_W-2:0], q.filt[PIN_DIN]};
      end
    end
    // shift out on falling edges, one or two bits at a time
    if (tx_fire) begin
      if (q.tx_cnt == CNT_RST) begin
        word           = tx_data;
        next_q.tx_load = 1'b1;
      end
      next_q.lane1_out = word[BYTE_W-1];
      if (dual_read) begin
        next_q.lane0_out = word[BYTE_W-2];
        next_q.tx_shift  = {word[BYTE_W-3:0], 2'h3};
        next_q.tx_cnt    = q.tx_cnt + CNT_TWO;
      end else begin
        next_q.tx_shift = {word[BYTE_W-2:0], 1'h1};
        next_q.tx_cnt   = q.tx_cnt + CNT_ONE;
      end
    end
    // pin drive and status
    next_q.lane1_oe = (next_q.fsm == SFPI_SEL) && !next_q.hold && read_phase;
    next_q.lane0_oe = (next_q.fsm == SFPI_SEL) && !next_q.hold && read_phase && dual_read;
    next_q.standby  = (next_q.fsm == SFPI_DESEL);
    next_q.hw_lock  = ~q.filt[PIN_WP];
    next_q.overrun  = q.push & ~buf_ready;
    if (rst) begin
      next_q           = '0;
      next_q.tx_shift  = BYTE_FILL;
      next_q.push_data = BYTE_RST;
      next_q.fsm       = SFPI_DESEL;
      next_q.standby   = 1'b1;
      next_q.filt      = PIN_IDLE;
      next_q.cs_prev   = PIN_IDLE[PIN_CS];
      next_q.sck_prev  = PIN_IDLE[PIN_SCK];
      for (int i = 0; i < PIN_N; i++) begin
        next_q.sync[i] = {SYNC_N{PIN_IDLE[i]}};
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    q <= next_q;
  end

  // ==========================================================
  // received byte buffer
  sfpi_buf2 #(
    .WIDTH     (BYTE_W)
  ) u_rx_buf (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   (q.push_data),
    .in_valid  (q.push),
    .in_ready  (buf_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // outputs straight from the state register
  assign din_lane0_out  = q.lane0_out;
  assign din_lane0_oe   = q.lane0_oe;
  assign dout_lane1_out = q.lane1_out;
  assign dout_lane1_oe  = q.lane1_oe;
  assign tx_load        = q.tx_load;
  assign rx_overrun     = q.overrun;
  assign frame_start    = q.frame_start;
  assign frame_end      = q.frame_end;
  assign standby        = q.standby;
  assign hw_lock        = q.hw_lock;
  assign paused         = q.hold;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_desel_lane_off: assert property ((q.fsm != SFPI_SEL) |-> !dout_lane1_oe && !din_lane0_oe)
    else $error("output lane driven while deselected");
  a_desel_no_rx: assert property ((q.fsm != SFPI_SEL) |-> !rx_fire)
    else $error("input sampled while deselected");
  a_frame_open: assert property (cs_fall && q.fsm != SFPI_SEL |=> q.fsm == SFPI_SEL && frame_start)
    else $error("select fall did not open a frame");
  a_finish_wait: assert property (q.fsm == SFPI_FINISH && self_timed_busy && !cs_fall |=> !standby)
    else $error("standby entered during self-timed work");
  a_rx_on_rise: assert property (rx_fire |-> $past(q.filt[PIN_SCK]) == 1'b0 && q.filt[PIN_SCK])
    else $error("input bit taken off a rising edge");
  a_tx_on_fall: assert property ($changed(dout_lane1_out) |-> $past(tx_fire))
    else $error("output lane changed off a falling edge");
  a_dual_lane: assert property (din_lane0_oe |-> dout_lane1_oe && $past(dual_read))
    else $error("lane zero driven outside dual read");
  a_wp_lock: assert property (!q.filt[PIN_WP] [*2] |-> hw_lock)
    else $error("protect pin low without lock");
  a_pause_quiet: assert property (q.hold |-> !rx_fire && !tx_fire && !dout_lane1_oe && !din_lane0_oe)
    else $error("activity while paused");
  a_pause_start: assert property ($rose(q.hold) |-> $past(q.fsm == SFPI_SEL && !q.filt[PIN_SCK]))
    else $error("pause started off select or with clock high");

endmodule : sfpi_top

`default_nettype wire

// ===== testbench/sfpi_host.sv
// host serial controller model driving select, clock and lane zero
`timescale 1ns/1ns
`default_nettype none

module sfpi_host (
  // clock
  input  wire logic ref_clk,
  // serial pins
  output var  logic cs_n,
  output var  logic sck,
  output var  logic mosi,
  output var  logic mosi_oe,
  input  wire logic lane0,
  input  wire logic lane1
);
  // pins idle deselected with clock low
  initial begin
    cs_n    = 1'b1;
    sck     = 1'b0;
    mosi    = 1'b0;
    mosi_oe = 1'b1;
  end

  // ==========================================================
  // bus phases
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_n

  // one pulse, eight cycles a phase; lanes taken at the rise
  task automatic pulse(input logic d, output logic [1:0] q);
    mosi = d;
    wait_n(8);
    sck = 1'b1;
    q = {lane1, lane0};
    wait_n(8);
    sck = 1'b0;
  endtask : pulse

  // whole byte, top bit first
  task automatic send(input logic [7:0] b);
    logic [1:0] q;
    for (int i = 7; i >= 0; i--) pulse(b[i], q);
  endtask : send

  // select edge with settling time around it
  task automatic select(input logic lvl);
    wait_n(8);
    cs_n = lvl;
    wait_n(8);
  endtask : select

  // hand lane zero to the device for dual reads
  task automatic let_go(input logic r);
    mosi_oe = ~r;
  endtask : let_go
endmodule : sfpi_host

`default_nettype wire

// ===== testbench/sfpi_top_tb_top.sv
// testbench of the serial flash pin front end
`timescale 1ns/1ns
`default_nettype none

module sfpi_top_tb_top;
  import sfpi_pkg::*;

  // ==========================================================
  // signals
  logic              ref_clk = 1'b0;
  logic              rst;
  logic              cs_n, sck, h_d, h_oe, lane0, lane1;
  logic              last0 = 1'b0;
  logic              last1 = 1'b0;
  logic              l0_out, l0_oe, l1_out, l1_oe;
  logic              wp_n;
  logic              pause_n;
  logic              read_phase;
  logic              dual_read;
  logic              busy;
  logic              rx_ready;
  logic [BYTE_W-1:0] tx_data;
  logic [BYTE_W-1:0] rx_data, got;
  logic [1:0]        q;
  logic              tx_load, rx_valid, rx_overrun, frame_start, frame_end, standby, hw_lock, paused;
  int                bad_count = 0;
  int                checks_done = 0;
  int                cyc = 0;
  int                n_fs, n_fe, n_ld, n_ov;

  always #25 ref_clk = ~ref_clk;

  // released lanes show the inverse of their last level
  assign lane0 = l0_oe ? l0_out : (h_oe ? h_d : ~last0);
  assign lane1 = l1_oe ? l1_out : ~last1;

  // pulse counters, lane history and hang guard
  always @(posedge ref_clk) begin
    last0 <= lane0;
    last1 <= lane1;
    n_fs <= n_fs + int'(frame_start);
    n_fe <= n_fe + int'(frame_end);
    n_ld <= n_ld + int'(tx_load);
    n_ov <= n_ov + int'(rx_overrun);
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      bad_count++;
      print_verdict();
    end
  end

  sfpi_host host (
    .ref_clk         (ref_clk),
    .cs_n            (cs_n),
    .sck             (sck),
    .mosi            (h_d),
    .mosi_oe         (h_oe),
    .lane0           (lane0),
    .lane1           (lane1)
  );

  sfpi_top dut (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .chip_select_n   (cs_n),
    .serial_clk      (sck),
    .din_lane0_in    (lane0),
    .din_lane0_out   (l0_out),
    .din_lane0_oe    (l0_oe),
    .dout_lane1_out  (l1_out),
    .dout_lane1_oe   (l1_oe),
    .write_protect_n (wp_n),
    .pause_n         (pause_n),
    .read_phase      (read_phase),
    .dual_read       (dual_read),
    .self_timed_busy (busy),
    .tx_data         (tx_data),
    .tx_load         (tx_load),
    .rx_data         (rx_data),
    .rx_valid        (rx_valid),
    .rx_ready        (rx_ready),
    .rx_overrun      (rx_overrun),
    .frame_start     (frame_start),
    .frame_end       (frame_end),
    .standby         (standby),
    .hw_lock         (hw_lock),
    .paused          (paused)
  );

  // ==========================================================
  // shared helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic clr();
    n_fs = 0;
    n_fe = 0;
    n_ld = 0;
    n_ov = 0;
  endtask : clr

  task automatic pop(input logic [7:0] exp);
    chk(rx_valid, 1'b1);
    chk(rx_data, exp);
    rx_ready = 1'b1;
    @(negedge ref_clk);
    rx_ready = 1'b0;
    @(negedge ref_clk);
  endtask : pop

  // ==========================================================
  // scenarios
  task automatic t_idle();
    clr();
    chk(standby, 1'b1);
    chk({l1_oe, l0_oe}, 2'b00);
    chk(hw_lock, 1'b0);
    for (int i = 0; i < 9; i++) host.pulse(1'b1, q);
    chk(rx_valid, 1'b0);
    chk(n_fs[7:0], 8'h00);
  endtask : t_idle

  // stalled consumer: two bytes kept, third lost, partial dropped
  task automatic t_write();
    clr();
    host.select(1'b0);
    chk(n_fs[7:0], 8'h01);
    chk(standby, 1'b0);
    host.send(8'hA5);
    host.send(8'h3C);
    host.send(8'h0F);
    for (int i = 0; i < 3; i++) host.pulse(1'b1, q);
    host.select(1'b1);
    chk(n_ov[7:0], 8'h01);
    chk(n_fe[7:0], 8'h01);
    pop(8'hA5);
    pop(8'h3C);
    chk(rx_valid, 1'b0);
  endtask : t_write

  // pause in mid-byte with clock low; pulses meanwhile ignored
  task automatic t_pause();
    clr();
    host.select(1'b0);
    for (int i = 7; i >= 4; i--) host.pulse(i > 5, q);
    pause_n = 1'b0;
    host.wait_n(8);
    chk(paused, 1'b1);
    for (int i = 0; i < 3; i++) host.pulse(1'b1, q);
    chk({l1_oe, n_fe[0]}, 2'b00);
    pause_n = 1'b1;
    host.wait_n(8);
    chk(paused, 1'b0);
    for (int i = 3; i >= 0; i--) host.pulse(i[0], q);
    host.select(1'b1);
    pop(8'hCA);
  endtask : t_pause

  // single lane read, one lead pulse before the first bit
  task automatic t_read();
    clr();
    tx_data = 8'h96;
    read_phase = 1'b1;
    host.select(1'b0);
    chk(l1_oe, 1'b1);
    host.pulse(1'b0, q);
    for (int i = 7; i >= 0; i--) begin
      host.pulse(1'b0, q);
      got[i] = q[1];
    end
    chk(got, 8'h96);
    host.select(1'b1);
    chk(n_ld[7:0], 8'h02);
    chk(l1_oe, 1'b0);
    read_phase = 1'b0;
  endtask : t_read

  // dual read, two bits a falling edge
  task automatic t_dual();
    tx_data = 8'hC9;
    read_phase = 1'b1;
    dual_read = 1'b1;
    host.let_go(1'b1);
    host.select(1'b0);
    chk(l0_oe, 1'b1);
    host.pulse(1'b0, q);
    for (int i = 3; i >= 0; i--) begin
      host.pulse(1'b0, q);
      got[2*i+1 -: 2] = q;
    end
    chk(got, 8'hC9);
    host.select(1'b1);
    chk({l0_oe, l1_oe}, 2'b00);
    {read_phase, dual_read} = 2'b00;
    host.let_go(1'b0);
  endtask : t_dual

  task automatic t_busy();
    busy = 1'b1;
    host.select(1'b0);
    host.select(1'b1);
    host.wait_n(20);
    chk(standby, 1'b0);
    busy = 1'b0;
    host.wait_n(4);
    chk(standby, 1'b1);
  endtask : t_busy

  task automatic t_protect();
    wp_n = 1'b0;
    host.wait_n(8);
    chk(hw_lock, 1'b1);
    wp_n = 1'b1;
    host.wait_n(8);
    chk(hw_lock, 1'b0);
  endtask : t_protect

  // ==========================================================
  // main sequence
  initial begin
    got        = 8'h00;
    rst        = 1'b1;
    wp_n       = 1'b1;
    pause_n    = 1'b1;
    read_phase = 1'b0;
    dual_read  = 1'b0;
    busy       = 1'b0;
    rx_ready   = 1'b0;
    tx_data    = 8'h00;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    host.wait_n(4);
    t_idle();
    t_write();
    t_pause();
    t_read();
    t_dual();
    t_busy();
    t_protect();
    print_verdict();
  end
endmodule : sfpi_top_tb_top

`default_nettype wire
